// [design/fpc_pkg.sv]
// Purpose: constants for the flash protection and programming control block
// Assumes: one 100 MHz clock, 18-bit byte address, 16-bit data
// Notes: pulse counts are in cpu clocks, referenced to a 20 MHz cpu
// Notes on behaviour
// - protection blocks flash data access and branches from outside code
// - code running in flash keeps reading and branching within flash
// - no erase or programming starts while protection is active
// - protection is on only when fuse bit and activation bit are both one
// - the activation bit is write-only and reads back as zero
// - fuse bit once seen at one stays one until reset, erase never clears it
// - a standard-mode control write changes only the activation bit
// - standard-mode activation write counts only from code in flash
// - control register is a direct word write to an even flash address
// - reset sets the activation bit
// - bit 0 enables flash writes, bit 1 picks erase over program
// - bits 6:5 set pulse width, 01 is 100 us at 20 MHz
// - bit 7 picks doubleword programming, else each word write programs
// - bit 15 holds writing mode, clearing it returns to standard mode
// - bit 4 shows whether programming voltage is in margin
// - doubleword: two writes to one address, low then high, second starts
// - bit 2 is busy for the whole pulse, drops when time elapses
// - completed programming enters program-verify mode
// - voltage leaving margin during an operation sets a sticky fault
// - erase mode targets the bank chosen by the bank-select field
// - clearing write enable leaves verify modes for non-verify mode
package fpc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CNT_W = 18;
  localparam int SEG_HI = 17;
  localparam int SEG_LO = 15;
  localparam logic [2:0] FLASH_SEG = 3'h2;
  localparam int WE_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int BUSY_BIT = 2;
  localparam int PROT_BIT = 3;
  localparam int HVOK_BIT = 4;
  localparam int TIMER_LO = 5;
  localparam int TIMER_HI = 6;
  localparam int DWORD_BIT = 7;
  localparam int BANK_LO = 8;
  localparam int BANK_HI = 9;
  localparam int FAULT_BIT = 10;
  localparam int HOLD_BIT = 15;
  localparam logic PROT_RST = 1'b1;
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_BRANCH = 2'h2;
  localparam logic [1:0] TIMER_00 = 2'h0;
  localparam logic [1:0] TIMER_01 = 2'h1;
  localparam logic [1:0] TIMER_10 = 2'h2;
  localparam int REF_MHZ = 20;
  localparam int PULSE_00_US = 10;
  localparam int PULSE_01_US = 100;
  localparam int PULSE_10_US = 1000;
  localparam int PULSE_11_US = 10000;
  localparam logic [CNT_W-1:0] PULSE_00_CYC = CNT_W'(PULSE_00_US * REF_MHZ);
  localparam logic [CNT_W-1:0] PULSE_01_CYC = CNT_W'(PULSE_01_US * REF_MHZ);
  localparam logic [CNT_W-1:0] PULSE_10_CYC = CNT_W'(PULSE_10_US * REF_MHZ);
  localparam logic [CNT_W-1:0] PULSE_11_CYC = CNT_W'(PULSE_11_US * REF_MHZ);
  typedef enum logic [1:0] {ST_STANDARD, ST_ARMED, ST_WRITING} fpc_state_type;
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} fpc_op_type;
endpackage : fpc_pkg

// [design/fpc_ctrl.sv]
// Purpose: flash protection gate, control register and program/erase sequencer
// Assumes: cpu request inputs synchronous to mclk, one request per cycle
// Notes: flash array itself lives outside; this block drives its pulses
`timescale 1ns/100ps
module fpc_ctrl #(
  parameter logic [fpc_pkg::CNT_W-1:0] PULSE_10_CYC = fpc_pkg::PULSE_10_CYC,
  parameter logic [fpc_pkg::CNT_W-1:0] PULSE_11_CYC = fpc_pkg::PULSE_11_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_direct,
  input wire logic req_word,
  input wire logic [fpc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fpc_pkg::DATA_W-1:0] req_wdata,
  input wire logic req_fetch_in_flash,
  input wire logic protect_fuse_enable,
  input wire logic hv_ok,
  output logic req_permit,
  output logic [fpc_pkg::DATA_W-1:0] fcr_rdata,
  output logic fcr_rvalid,
  output logic arr_prog_pulse,
  output logic arr_erase_pulse,
  output logic [fpc_pkg::ADDR_W-1:0] arr_addr,
  output logic [2*fpc_pkg::DATA_W-1:0] arr_data,
  output logic arr_dword,
  output logic [1:0] arr_bank,
  output logic program_verify_mode,
  output logic erase_verify_mode,
  output logic writing_mode,
  output logic protect_on
);
  logic rst_meta_r;
  logic rst_sync_n;
  fpc_pkg::fpc_state_type st_r, st_nxt;
  fpc_pkg::fpc_op_type op_r, op_nxt;
  logic [fpc_pkg::CNT_W-1:0] cnt_r, cnt_nxt, pulse_len;
  logic prot_r, prot_nxt, fuse_r, fuse_nxt;
  logic we_r, we_nxt, erase_r, erase_nxt, dword_r, dword_nxt;
  logic hold_r, hold_nxt, fault_r, fault_nxt;
  logic pvm_r, pvm_nxt, evm_r, evm_nxt, half_r, half_nxt;
  logic [1:0] timer_r, timer_nxt, bank_r, bank_nxt;
  logic [fpc_pkg::ADDR_W-1:0] half_addr_r, half_addr_nxt;
  logic [fpc_pkg::ADDR_W-1:0] aaddr_r, aaddr_nxt;
  logic [fpc_pkg::DATA_W-1:0] low_r, low_nxt, rdata_r, rdata_nxt;
  logic [2*fpc_pkg::DATA_W-1:0] adata_r, adata_nxt;
  logic adword_r, adword_nxt, rvalid_r, rvalid_nxt;
  logic in_flash, blocked, fcr_wr, fcr_rd, ind_wr, busy, may_start;
  logic addr_key;
  logic [fpc_pkg::DATA_W-1:0] fcr_view;

  // reset released through two flops, asserted at once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  assign in_flash = req_addr[fpc_pkg::SEG_HI:fpc_pkg::SEG_LO] ==
                    fpc_pkg::FLASH_SEG;
  assign protect_on = fuse_r & prot_r;
  assign busy = op_r != fpc_pkg::OP_IDLE;
  // inside code is never blocked, outside code never reaches flash while protection is on
  assign blocked = protect_on & in_flash & ~req_fetch_in_flash;
  assign req_permit = ~blocked;
  // control register: direct word access to any even flash address
  assign fcr_wr = req_valid & ~blocked & req_kind == fpc_pkg::KIND_WRITE &
                  req_direct & req_word & in_flash & ~req_addr[0];
  assign fcr_rd = req_valid & ~blocked & req_kind == fpc_pkg::KIND_READ &
                  req_direct & req_word & in_flash & ~req_addr[0];
  assign ind_wr = req_valid & ~blocked & req_kind == fpc_pkg::KIND_WRITE &
                  ~req_direct & req_word & in_flash & ~req_addr[0];
  assign addr_key = req_wdata == req_addr[fpc_pkg::DATA_W-1:0];
  assign may_start = st_r == fpc_pkg::ST_WRITING & we_r & ~busy &
                     ~protect_on;

  always_comb begin
    case (timer_r)
      fpc_pkg::TIMER_00: pulse_len = fpc_pkg::PULSE_00_CYC;
      fpc_pkg::TIMER_01: pulse_len = fpc_pkg::PULSE_01_CYC;
      fpc_pkg::TIMER_10: pulse_len = PULSE_10_CYC;
      default: pulse_len = PULSE_11_CYC;
    endcase
  end

  // activation bit never shows on reads
  always_comb begin
    fcr_view = '0;
    fcr_view[fpc_pkg::WE_BIT] = we_r;
    fcr_view[fpc_pkg::ERASE_BIT] = erase_r;
    fcr_view[fpc_pkg::BUSY_BIT] = busy;
    fcr_view[fpc_pkg::PROT_BIT] = 1'b0;
    fcr_view[fpc_pkg::HVOK_BIT] = hv_ok;
    fcr_view[fpc_pkg::TIMER_HI:fpc_pkg::TIMER_LO] = timer_r;
    fcr_view[fpc_pkg::DWORD_BIT] = dword_r;
    fcr_view[fpc_pkg::BANK_HI:fpc_pkg::BANK_LO] = bank_r;
    fcr_view[fpc_pkg::FAULT_BIT] = fault_r;
    fcr_view[fpc_pkg::HOLD_BIT] = hold_r;
  end

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    cnt_nxt = cnt_r;
    prot_nxt = prot_r;
    fuse_nxt = fuse_r | protect_fuse_enable;
    we_nxt = we_r;
    erase_nxt = erase_r;
    dword_nxt = dword_r;
    hold_nxt = hold_r;
    fault_nxt = fault_r;
    pvm_nxt = pvm_r;
    evm_nxt = evm_r;
    half_nxt = half_r;
    timer_nxt = timer_r;
    bank_nxt = bank_r;
    half_addr_nxt = half_addr_r;
    aaddr_nxt = aaddr_r;
    low_nxt = low_r;
    adata_nxt = adata_r;
    adword_nxt = adword_r;
    rdata_nxt = rdata_r;
    // only writing-mode control reads load rdata; other reads drop rvalid and rdata holds
    rvalid_nxt = fcr_rd & st_r == fpc_pkg::ST_WRITING;
    if (rvalid_nxt) begin
      rdata_nxt = fcr_view;
    end
    case (st_r)
      fpc_pkg::ST_STANDARD: begin
        if (fcr_wr) begin
          // only the activation bit, and only from flash-resident code
          if (req_fetch_in_flash) begin
            prot_nxt = req_wdata[fpc_pkg::PROT_BIT];
          end
          st_nxt = fpc_pkg::ST_ARMED;
        end
      end
      fpc_pkg::ST_ARMED: begin
        // any other access in between breaks the key sequence
        if (ind_wr && addr_key) begin
          st_nxt = fpc_pkg::ST_WRITING;
        end else if (req_valid) begin
          st_nxt = fpc_pkg::ST_STANDARD;
        end
      end
      fpc_pkg::ST_WRITING: begin
        if (fcr_wr && !busy) begin
          // fields frozen while a pulse runs, so timing cannot shift
          we_nxt = req_wdata[fpc_pkg::WE_BIT];
          erase_nxt = req_wdata[fpc_pkg::ERASE_BIT];
          prot_nxt = req_wdata[fpc_pkg::PROT_BIT];
          timer_nxt = req_wdata[fpc_pkg::TIMER_HI:fpc_pkg::TIMER_LO];
          dword_nxt = req_wdata[fpc_pkg::DWORD_BIT];
          bank_nxt = req_wdata[fpc_pkg::BANK_HI:fpc_pkg::BANK_LO];
          hold_nxt = req_wdata[fpc_pkg::HOLD_BIT];
          if (!req_wdata[fpc_pkg::WE_BIT]) begin
            pvm_nxt = 1'b0;
            evm_nxt = 1'b0;
            half_nxt = 1'b0;
          end
          if (!req_wdata[fpc_pkg::HOLD_BIT]) begin
            st_nxt = fpc_pkg::ST_STANDARD;
            half_nxt = 1'b0;
          end
        end else if (ind_wr && may_start) begin
          if (erase_r) begin
            if (addr_key) begin
              op_nxt = fpc_pkg::OP_ERASE;
              aaddr_nxt = req_addr;
            end
          end else if (dword_r) begin
            if (half_r && req_addr[fpc_pkg::ADDR_W-1:2] ==
                half_addr_r[fpc_pkg::ADDR_W-1:2]) begin
              op_nxt = fpc_pkg::OP_PROG;
              adata_nxt = {req_wdata, low_r};
              aaddr_nxt = half_addr_r;
              half_nxt = 1'b0;
            end else begin
              // first half only latched; an address outside its doubleword restarts pairing
              low_nxt = req_wdata;
              half_addr_nxt = req_addr;
              half_nxt = 1'b1;
            end
          end else begin
            op_nxt = fpc_pkg::OP_PROG;
            adata_nxt = {{fpc_pkg::DATA_W{1'b0}}, req_wdata};
            aaddr_nxt = req_addr;
          end
          if (op_nxt != fpc_pkg::OP_IDLE) begin
            cnt_nxt = pulse_len;
            adword_nxt = dword_r & ~erase_r;
            pvm_nxt = 1'b0;
            evm_nxt = 1'b0;
            fault_nxt = 1'b0;
          end
        end
      end
      default: st_nxt = fpc_pkg::ST_STANDARD;
    endcase
    if (busy) begin
      // set after start clear, so an early dip is never lost
      if (!hv_ok) begin
        fault_nxt = 1'b1;
      end
      cnt_nxt = cnt_r - 1'b1;
      if (cnt_r == {{(fpc_pkg::CNT_W-1){1'b0}}, 1'b1}) begin
        op_nxt = fpc_pkg::OP_IDLE;
        pvm_nxt = op_r == fpc_pkg::OP_PROG;
        evm_nxt = op_r == fpc_pkg::OP_ERASE;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= fpc_pkg::ST_STANDARD;
      op_r <= fpc_pkg::OP_IDLE;
      cnt_r <= '0;
      prot_r <= fpc_pkg::PROT_RST;
      fuse_r <= 1'b0;
      we_r <= 1'b0;
      erase_r <= 1'b0;
      dword_r <= 1'b0;
      hold_r <= 1'b0;
      fault_r <= 1'b0;
      pvm_r <= 1'b0;
      evm_r <= 1'b0;
      half_r <= 1'b0;
      timer_r <= '0;
      bank_r <= '0;
      half_addr_r <= '0;
      aaddr_r <= '0;
      low_r <= '0;
      adata_r <= '0;
      adword_r <= 1'b0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      cnt_r <= cnt_nxt;
      prot_r <= prot_nxt;
      fuse_r <= fuse_nxt;
      we_r <= we_nxt;
      erase_r <= erase_nxt;
      dword_r <= dword_nxt;
      hold_r <= hold_nxt;
      fault_r <= fault_nxt;
      pvm_r <= pvm_nxt;
      evm_r <= evm_nxt;
      half_r <= half_nxt;
      timer_r <= timer_nxt;
      bank_r <= bank_nxt;
      half_addr_r <= half_addr_nxt;
      aaddr_r <= aaddr_nxt;
      low_r <= low_nxt;
      adata_r <= adata_nxt;
      adword_r <= adword_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign fcr_rdata = rdata_r;
  assign fcr_rvalid = rvalid_r;
  assign arr_prog_pulse = op_r == fpc_pkg::OP_PROG;
  assign arr_erase_pulse = op_r == fpc_pkg::OP_ERASE;
  assign arr_addr = aaddr_r;
  assign arr_data = adata_r;
  assign arr_dword = adword_r;
  assign arr_bank = bank_r;
  assign program_verify_mode = pvm_r;
  assign erase_verify_mode = evm_r;
  assign writing_mode = st_r == fpc_pkg::ST_WRITING;

  // helper: length of the last busy stretch against the loaded length
  logic [fpc_pkg::CNT_W-1:0] chk_len_r, chk_exp_r;
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chk_len_r <= '0;
      chk_exp_r <= '0;
    end else if (!busy && op_nxt != fpc_pkg::OP_IDLE) begin
      chk_len_r <= '0;
      chk_exp_r <= cnt_nxt;
    end else if (busy) begin
      chk_len_r <= chk_len_r + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  a_prot_block_out: assert property (protect_on && req_valid && in_flash &&
    !req_fetch_in_flash |-> !req_permit ##1 $stable(we_r))
    else $error("outside access to protected flash not blocked");
  a_prot_inside_ok: assert property (req_valid && req_fetch_in_flash
    |-> req_permit) else $error("flash code access refused");
  a_prot_no_start: assert property ($rose(busy) |-> !$past(protect_on))
    else $error("operation started under protection");
  a_prot_needs_fuse: assert property (!fuse_r |-> !protect_on)
    else $error("protection active without fuse");
  a_fuse_sticky: assert property (fuse_r |=> fuse_r [*3])
    else $error("fuse bit cleared");
  a_std_write_only: assert property (st_r == fpc_pkg::ST_STANDARD && fcr_wr
    |=> $stable(we_r) && $stable(timer_r) && $stable(hold_r))
    else $error("standard write changed other fields");
  a_std_ram_write: assert property (st_r == fpc_pkg::ST_STANDARD && fcr_wr &&
    !req_fetch_in_flash |=> $stable(prot_r))
    else $error("activation changed from outside code");
  a_reset_prot: assert property ($rose(rst_sync_n) |-> prot_r)
    else $error("activation bit not set after reset");
  a_busy_len: assert property ($fell(busy) |-> chk_len_r == chk_exp_r)
    else $error("busy length differs from timer setting");
  a_verify_entry: assert property ($fell(busy) && $past(arr_prog_pulse)
    |-> program_verify_mode && !erase_verify_mode)
    else $error("no program-verify after programming");
  a_fault_sticky: assert property (busy && !hv_ok |=> fault_r [*2])
    else $error("voltage fault not held");
  a_dword_first: assert property (ind_wr && may_start && dword_r &&
    !erase_r && !half_r |=> !busy && half_r)
    else $error("first doubleword write started programming");
  a_we_clear: assert property (st_r == fpc_pkg::ST_WRITING && fcr_wr &&
    !busy && !req_wdata[fpc_pkg::WE_BIT] |=> !pvm_r && !evm_r)
    else $error("verify mode kept after write enable cleared");

  c_unlock: cover property (st_r == fpc_pkg::ST_ARMED ##1 writing_mode);
  c_dword_prog: cover property ($rose(arr_prog_pulse) && arr_dword);
  c_erase_done: cover property ($fell(arr_erase_pulse) ##1 erase_verify_mode);
  c_blocked: cover property (req_valid && !req_permit);
endmodule : fpc_ctrl

// [sim/fpc_cpu_model.sv]
// Purpose: cpu core model driving the flash control request port
// Assumes: one access per clock, launched 1 ns after the rising edge
// Notes: address and data toggle while idle, so a stale value never helps
`timescale 1ns/100ps
module fpc_cpu_model (
  input wire logic mclk,
  input wire logic req_permit,
  output logic req_valid,
  output logic [1:0] req_kind,
  output logic req_direct,
  output logic req_word,
  output logic [fpc_pkg::ADDR_W-1:0] req_addr,
  output logic [fpc_pkg::DATA_W-1:0] req_wdata,
  output logic req_fetch_in_flash
);
  localparam logic [17:0] CTRL_A = 18'h10000;
  logic permit_seen;
  initial begin
    req_valid = 1'b0;
    req_kind = 2'h0;
    req_direct = 1'b0;
    req_word = 1'b1;
    req_addr = 18'h00000;
    req_wdata = 16'h0000;
    req_fetch_in_flash = 1'b0;
    permit_seen = 1'b0;
  end
  // request held up to the taking edge, permit sampled before it
  task automatic access(input logic [1:0] kind, input logic direct,
      input logic [17:0] addr, input logic [15:0] data, input logic fl);
    req_valid = 1'b1;
    req_kind = kind;
    req_direct = direct;
    req_addr = addr;
    req_wdata = data;
    req_fetch_in_flash = fl;
    #1;
    permit_seen = req_permit;
    @(posedge mclk);
    #1;
  endtask : access
  task automatic idle(input int n);
    req_valid = 1'b0;
    repeat (n) begin
      req_addr = ~req_addr;
      req_wdata = ~req_wdata;
      @(posedge mclk);
      #1;
    end
  endtask : idle
  task automatic one(input logic [1:0] kind, input logic direct,
      input logic [17:0] addr, input logic [15:0] data, input logic fl);
    access(kind, direct, addr, data, fl);
    idle(1);
  endtask : one
  // byte operand at a control address, only word accesses may count
  task automatic narrow(input logic [1:0] kind, input logic [17:0] addr,
      input logic [15:0] data);
    req_word = 1'b0;
    access(kind, 1'b1, addr, data, 1'b1);
    req_word = 1'b1;
    idle(1);
  endtask : narrow
  task automatic ctrl(input logic [15:0] data, input logic fl);
    one(fpc_pkg::KIND_WRITE, 1'b1, CTRL_A, data, fl);
  endtask : ctrl
  task automatic unlock(input logic [17:0] addr);
    access(fpc_pkg::KIND_WRITE, 1'b1, CTRL_A, 16'h0000, 1'b0);
    one(fpc_pkg::KIND_WRITE, 1'b0, addr, addr[15:0], 1'b0);
    idle(1000);
  endtask : unlock
  // no gap between the halves, an interrupt here would split the pair
  task automatic dword(input logic [17:0] addr, input logic [15:0] lo,
      input logic [15:0] hi);
    access(fpc_pkg::KIND_WRITE, 1'b0, addr, lo, 1'b0);
    one(fpc_pkg::KIND_WRITE, 1'b0, addr, hi, 1'b0);
  endtask : dword
endmodule : fpc_cpu_model

// [sim/tb_flash_protect_program_ctrl.sv]
// Purpose: self-checking bench for flash protection and program control
// Assumes: cpu model issues accesses, bench drives fuse and voltage levels
// Notes: timer codes 10 and 11 shortened to 20 and 30 cycles
`timescale 1ns/100ps
module tb_flash_protect_program_ctrl;
  localparam logic [1:0] RD = fpc_pkg::KIND_READ;
  localparam logic [1:0] WR = fpc_pkg::KIND_WRITE;
  localparam logic [1:0] BR = fpc_pkg::KIND_BRANCH;
  logic mclk, rstn, protect_fuse_enable, hv_ok, req_permit, fcr_rvalid;
  logic req_valid, req_direct, req_word, req_fetch_in_flash, arr_dword;
  logic [1:0] req_kind, arr_bank;
  logic [17:0] req_addr, arr_addr;
  logic [15:0] req_wdata, fcr_rdata;
  logic [31:0] arr_data;
  logic arr_prog_pulse, arr_erase_pulse, program_verify_mode;
  logic erase_verify_mode, writing_mode, protect_on;
  int n_fail, comparisons, cycles;
  fpc_cpu_model cpu (.mclk(mclk), .req_permit(req_permit),
    .req_valid(req_valid), .req_kind(req_kind), .req_direct(req_direct),
    .req_word(req_word), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_fetch_in_flash(req_fetch_in_flash));
  fpc_ctrl #(.PULSE_10_CYC(18'h00014), .PULSE_11_CYC(18'h0001E)) i_dut (
    .mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req_kind(req_kind),
    .req_direct(req_direct), .req_word(req_word), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_fetch_in_flash(req_fetch_in_flash),
    .protect_fuse_enable(protect_fuse_enable), .hv_ok(hv_ok),
    .req_permit(req_permit), .fcr_rdata(fcr_rdata),
    .fcr_rvalid(fcr_rvalid), .arr_prog_pulse(arr_prog_pulse),
    .arr_erase_pulse(arr_erase_pulse), .arr_addr(arr_addr),
    .arr_data(arr_data), .arr_dword(arr_dword), .arr_bank(arr_bank),
    .program_verify_mode(program_verify_mode),
    .erase_verify_mode(erase_verify_mode), .writing_mode(writing_mode),
    .protect_on(protect_on));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic test_done();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  // a hang ends the run here, far beyond the ~6000 cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd(input logic [15:0] exp);
    cpu.access(RD, 1'b1, 18'h10000, 16'h0000, 1'b0);
    check({fcr_rvalid, fcr_rdata}, {1'b1, exp});
    cpu.idle(1);
  endtask : rd
  // entered one cycle after the start, that cycle counted blind
  task automatic pulse_len(output int n);
    cpu.idle(1);
    n = 1;
    while ((arr_prog_pulse === 1'b1 || arr_erase_pulse === 1'b1)
        && n < 3000) begin
      n++;
      cpu.idle(1);
    end
  endtask : pulse_len
  task automatic s_gate();
    cpu.one(RD, 1'b0, 18'h10100, 16'h0000, 1'b0);
    check(cpu.permit_seen, 1'b0);
    cpu.one(BR, 1'b1, 18'h10100, 16'h0000, 1'b0);
    check(cpu.permit_seen, 1'b0);
    cpu.one(BR, 1'b1, 18'h10100, 16'h0000, 1'b1);
    check(cpu.permit_seen, 1'b1);
    cpu.one(RD, 1'b0, 18'h00100, 16'h0000, 1'b0);
    check(cpu.permit_seen, 1'b1);
    cpu.access(RD, 1'b1, 18'h10000, 16'h0000, 1'b1);
    check(fcr_rvalid, 1'b0);
    cpu.idle(1);
    cpu.ctrl(16'h0000, 1'b0);
    check(protect_on, 1'b1);
    cpu.ctrl(16'hFFF7, 1'b1);
    check({protect_on, writing_mode}, 2'b00);
    // any access but the key drops the armed unlock back to standard
    cpu.one(RD, 1'b0, 18'h10100, 16'h0000, 1'b0);
    check(cpu.permit_seen, 1'b1);
  endtask : s_gate
  task automatic s_config();
    cpu.unlock(18'h10010);
    check(writing_mode, 1'b1);
    cpu.ctrl(16'h80A1, 1'b0);
    cpu.narrow(WR, 18'h10000, 16'h0000);
    rd(16'h80B1);
    hv_ok = 1'b0;
    rd(16'h80A1);
    hv_ok = 1'b1;
  endtask : s_config
  task automatic s_dword();
    int n;
    cpu.dword(18'h10020, 16'h1234, 16'hABCD);
    check({arr_prog_pulse, arr_dword}, 2'b11);
    check(arr_data, 32'hABCD1234);
    check(arr_addr, 18'h10020);
    hv_ok = 1'b0;
    cpu.idle(1);
    hv_ok = 1'b1;
    rd(16'h84B5);
    pulse_len(n);
    check(n, 1996);
    check(program_verify_mode, 1'b1);
    rd(16'h84B1);
    cpu.ctrl(16'h8000, 1'b0);
    check(program_verify_mode, 1'b0);
  endtask : s_dword
  task automatic s_timers();
    int tab [4] = '{200, 2000, 20, 30};
    int n;
    for (int t = 0; t < 4; t++) begin
      cpu.ctrl(16'h8001 | (16'(t) << 5), 1'b0);
      cpu.access(WR, 1'b0, 18'h10030, 16'h5A5A, 1'b0);
      check({arr_dword, arr_data}, {1'b0, 32'h00005A5A});
      pulse_len(n);
      check(n, tab[t]);
    end
  endtask : s_timers
  task automatic s_erase();
    int n;
    cpu.ctrl(16'h8303, 1'b0);
    cpu.one(WR, 1'b0, 18'h10040, 16'h1234, 1'b0);
    check(arr_erase_pulse, 1'b0);
    cpu.access(WR, 1'b0, 18'h10040, 16'h0040, 1'b0);
    check({arr_erase_pulse, arr_prog_pulse, arr_bank}, 4'hB);
    pulse_len(n);
    check(n, 200);
    check({erase_verify_mode, program_verify_mode}, 2'b10);
  endtask : s_erase
  task automatic s_lock();
    cpu.ctrl(16'h8009, 1'b0);
    check(protect_on, 1'b1);
    cpu.access(RD, 1'b1, 18'h10000, 16'h0000, 1'b1);
    check({fcr_rvalid, fcr_rdata}, 17'h18011);
    cpu.idle(1);
    cpu.one(WR, 1'b0, 18'h10050, 16'h0050, 1'b0);
    check({cpu.permit_seen, arr_prog_pulse}, 2'b00);
    cpu.one(WR, 1'b0, 18'h10050, 16'h0050, 1'b1);
    check({cpu.permit_seen, arr_prog_pulse}, 2'b10);
    cpu.ctrl(16'h0000, 1'b1);
    check({writing_mode, protect_on}, 2'b00);
    // protection off, so only the fetch origin can stop this one
    cpu.ctrl(16'h0008, 1'b0);
    check(protect_on, 1'b0);
    cpu.one(RD, 1'b0, 18'h00100, 16'h0000, 1'b0);
    cpu.ctrl(16'h8009, 1'b1);
    check({protect_on, writing_mode}, 2'b10);
  endtask : s_lock
  // second reset with the fuse input low: activation alone is not enough
  task automatic s_reset();
    rstn = 1'b0;
    cpu.idle(2);
    rstn = 1'b1;
    cpu.idle(4);
    check({protect_on, writing_mode}, 2'b00);
    cpu.one(RD, 1'b0, 18'h10100, 16'h0000, 1'b0);
    check(cpu.permit_seen, 1'b1);
  endtask : s_reset
  initial begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    rstn = 1'b0;
    protect_fuse_enable = 1'b1;
    hv_ok = 1'b1;
    repeat (16) @(posedge mclk);
    #1;
    rstn = 1'b1;
    cpu.idle(4);
    check(protect_on, 1'b1);
    protect_fuse_enable = 1'b0;
    s_gate();
    s_config();
    s_dword();
    s_timers();
    s_erase();
    s_lock();
    s_reset();
    test_done();
  end
endmodule : tb_flash_protect_program_ctrl
